// ==== include/sfsr_pkg.sv ====
// constants shared by both ends of the status readout link
// Functional notes
// - status read served anytime, even while busy
// - opcode 05h streams status byte one
// - opcode 35h streams status byte two
// - msb first, byte repeats while clocks continue
// - every repeat carries live register contents
// - chip select release ends read, output off
// - byte three read 15h, written 11h
// - byte one: guard zero, five block guards
// - byte one bit1 read-only write latch
// - byte one bit0 read-only busy flag
// - status write changes only writable bits
// - byte two bit7 read-only erase paused
// - byte two bits5:3 secure page locks
// - byte two bit2 read-only program paused
// - byte two bit1 quad enable, default 0
// - byte two bit6 invert, bit0 guard one
// - byte three bits6:5 strength, default 11
// - write latch cleared by reset
package sfsr_pkg;
  // opcodes
  localparam logic [7:0] OP_READ_ONE = 8'h05;
  localparam logic [7:0] OP_READ_TWO = 8'h35;
  localparam logic [7:0] OP_READ_THREE = 8'h15;
  localparam logic [7:0] OP_WRITE_ONE = 8'h01;
  localparam logic [7:0] OP_WRITE_TWO = 8'h31;
  localparam logic [7:0] OP_WRITE_THREE = 8'h11;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  // byte selectors
  localparam logic [1:0] SEL_ONE = 2'h0;
  localparam logic [1:0] SEL_TWO = 2'h1;
  localparam logic [1:0] SEL_THREE = 2'h2;
  // writable masks and reset values of the stored bits
  localparam logic [7:0] WR_MASK_ONE = 8'hfc;
  localparam logic [7:0] WR_MASK_TWO = 8'h7b;
  localparam logic [7:0] WR_MASK_THREE = 8'h60;
  localparam logic [7:0] RST_ONE = 8'h00;
  localparam logic [7:0] RST_TWO = 8'h00;
  localparam logic [7:0] RST_THREE = 8'h60;
  // field positions
  localparam int BIT_ERASE_PAUSED = 7;
  localparam int BIT_PROGRAM_PAUSED = 2;
  localparam int BIT_QUAD = 1;
  localparam int BIT_INVERT = 6;
  localparam int BIT_GUARD_ONE = 0;
  localparam int BIT_GUARD_ZERO = 7;
  localparam int BIT_WRITE_LATCH = 1;
  localparam int BIT_BUSY = 0;
  localparam logic [2:0] BIT_MSB = 3'h7;
  // host register map, byte addresses
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h0c;
  localparam logic [7:0] ADR_IRQ_EN = 8'h10;
  // link clock made by the host
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 160;
  localparam logic [7:0] SCK_HALF_CYC = 8'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
endpackage

// ==== include/sfsr_spi_if.sv ====
// serial link between the status readout device and its host
`timescale 1ns/1ns
interface sfsr_spi_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  // pulled-high line when the device is not driving
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev (input sck, input cs_n, input mosi, output miso, output miso_oe);
  modport host (output sck, output cs_n, output mosi, input miso_line);
endinterface

// ==== hw/sfsr_device.sv ====
// flash-side status register bank with serial read and write
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
module sfsr_device
  import sfsr_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic srst,
  // serial link
  sfsr_spi_if.dev link,
  // live state from the array engine
  input wire logic busy_in,
  input wire logic erase_paused_in,
  input wire logic program_paused_in,
  // configuration for array and pads
  output logic [4:0] block_guard,
  output logic status_guard_zero,
  output logic status_guard_one,
  output logic protect_invert,
  output logic [2:0] secure_page_lock,
  output logic quad_io_enable,
  output logic [1:0] output_strength_field,
  output logic write_latch_flag
);
  typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_READ, ST_WRITE, ST_IGNORE} sfsr_dev_state_t;

  // merge written data into the stored byte, writable bits only
  function automatic logic [7:0] sfsr_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] mask);
    sfsr_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  logic [2:0] sck_s_q;
  logic [2:0] sck_s_d;
  logic [2:0] cs_s_q;
  logic [2:0] cs_s_d;
  logic [1:0] mosi_s_q;
  logic [1:0] mosi_s_d;
  logic sck_rise;
  logic sck_fall;
  logic cs_idle;
  logic cs_end;
  logic mosi_bit;

  // two-stage synchronisers; third stage only for edge finding
  always_comb begin
    sck_s_d = {sck_s_q[1:0], link.sck};
    cs_s_d = {cs_s_q[1:0], link.cs_n};
    mosi_s_d = {mosi_s_q[0], link.mosi};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sck_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      mosi_s_q <= 2'h0;
    end else begin
      sck_s_q <= sck_s_d;
      cs_s_q <= cs_s_d;
      mosi_s_q <= mosi_s_d;
    end
  end

  // edges and levels taken from settled stages only
  assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
  assign sck_fall = ~sck_s_q[1] & sck_s_q[2];
  assign cs_idle = cs_s_q[1];
  assign cs_end = cs_s_q[1] & ~cs_s_q[2];
  assign mosi_bit = mosi_s_q[1];

  sfsr_dev_state_t state_q;
  sfsr_dev_state_t state_d;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [7:0] shin_q;
  logic [7:0] shin_d;
  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic [7:0] snap_q;
  logic [7:0] snap_d;
  logic [7:0] wr_data_q;
  logic [7:0] wr_data_d;
  logic wr_full_q;
  logic wr_full_d;
  logic wr_over_q;
  logic wr_over_d;
  logic miso_q;
  logic miso_d;
  logic oe_q;
  logic oe_d;
  logic [7:0] rw1_q;
  logic [7:0] rw1_d;
  logic [7:0] rw2_q;
  logic [7:0] rw2_d;
  logic [7:0] rw3_q;
  logic [7:0] rw3_d;
  logic wel_q;
  logic wel_d;
  logic [7:0] live_byte;
  logic [7:0] op_byte;

  // live view of the selected byte; busy and paused bits come straight from the engine, the write latch bit from wel_q
  always_comb begin
    case (sel_q)
      SEL_ONE: begin
        live_byte = rw1_q & WR_MASK_ONE;
        live_byte[BIT_WRITE_LATCH] = wel_q;
        live_byte[BIT_BUSY] = busy_in;
      end
      SEL_TWO: begin
        live_byte = rw2_q & WR_MASK_TWO;
        live_byte[BIT_ERASE_PAUSED] = erase_paused_in;
        live_byte[BIT_PROGRAM_PAUSED] = program_paused_in;
      end
      SEL_THREE: begin
        live_byte = rw3_q & WR_MASK_THREE;
      end
      default: begin
        live_byte = 8'h00;
      end
    endcase
  end

  assign op_byte = {shin_q[6:0], mosi_bit};

  // command decode, shifting and status updates
  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    shin_d = shin_q;
    sel_d = sel_q;
    idx_d = idx_q;
    snap_d = snap_q;
    wr_data_d = wr_data_q;
    wr_full_d = wr_full_q;
    wr_over_d = wr_over_q;
    miso_d = miso_q;
    oe_d = oe_q;
    rw1_d = rw1_q;
    rw2_d = rw2_q;
    rw3_d = rw3_q;
    wel_d = wel_q;
    if (cs_idle) begin
      // release at any bit ends the command and floats the output
      state_d = ST_IDLE;
      oe_d = 1'b0;
      bit_d = 3'h0;
      if (cs_end && state_q == ST_WRITE) begin
        // latch drops once a full write opcode was seen, applied or not
        wel_d = 1'b0;
        if (wr_full_q && !wr_over_q && wel_q) begin
          case (sel_q)
            SEL_ONE: rw1_d = sfsr_merge(rw1_q, wr_data_q, WR_MASK_ONE);
            SEL_TWO: rw2_d = sfsr_merge(rw2_q, wr_data_q, WR_MASK_TWO);
            SEL_THREE: rw3_d = sfsr_merge(rw3_q, wr_data_q, WR_MASK_THREE);
            default: rw1_d = rw1_q;
          endcase
        end
      end
    end else begin
      if (state_q == ST_IDLE) begin
        state_d = ST_OPCODE;
      end
      if (sck_rise) begin
        shin_d = op_byte;
        bit_d = bit_q + 3'h1;
        if ((state_q == ST_IDLE || state_q == ST_OPCODE) && bit_q == BIT_MSB) begin
          idx_d = BIT_MSB;
          wr_full_d = 1'b0;
          wr_over_d = 1'b0;
          // reads are decoded regardless of busy
          case (op_byte)
            OP_READ_ONE: begin
              state_d = ST_READ;
              sel_d = SEL_ONE;
            end
            OP_READ_TWO: begin
              state_d = ST_READ;
              sel_d = SEL_TWO;
            end
            OP_READ_THREE: begin
              state_d = ST_READ;
              sel_d = SEL_THREE;
            end
            OP_WRITE_ONE: begin
              state_d = ST_WRITE;
              sel_d = SEL_ONE;
            end
            OP_WRITE_TWO: begin
              state_d = ST_WRITE;
              sel_d = SEL_TWO;
            end
            OP_WRITE_THREE: begin
              state_d = ST_WRITE;
              sel_d = SEL_THREE;
            end
            OP_WRITE_ENABLE: begin
              state_d = ST_IGNORE;
              wel_d = 1'b1;
            end
            OP_WRITE_DISABLE: begin
              state_d = ST_IGNORE;
              wel_d = 1'b0;
            end
            default: begin
              state_d = ST_IGNORE;
            end
          endcase
        end else if (state_q == ST_WRITE && bit_q == BIT_MSB) begin
          // any bit past the first data byte spoils the write
          if (wr_full_q) begin
            wr_over_d = 1'b1;
          end else begin
            wr_full_d = 1'b1;
            wr_data_d = op_byte;
          end
        end else if (state_q == ST_WRITE && wr_full_q) begin
          wr_over_d = 1'b1;
        end
      end
      if (sck_fall && state_q == ST_READ) begin
        // fresh snapshot at each byte start keeps the bits of one byte coherent
        oe_d = 1'b1;
        idx_d = idx_q - 3'h1;
        if (idx_q == BIT_MSB) begin
          snap_d = live_byte;
          miso_d = live_byte[BIT_MSB];
        end else begin
          miso_d = snap_q[idx_q];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_IDLE;
      bit_q <= 3'h0;
      shin_q <= 8'h00;
      sel_q <= SEL_ONE;
      idx_q <= BIT_MSB;
      snap_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_full_q <= 1'b0;
      wr_over_q <= 1'b0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
      rw1_q <= RST_ONE;
      rw2_q <= RST_TWO;
      rw3_q <= RST_THREE;
      wel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      shin_q <= shin_d;
      sel_q <= sel_d;
      idx_q <= idx_d;
      snap_q <= snap_d;
      wr_data_q <= wr_data_d;
      wr_full_q <= wr_full_d;
      wr_over_q <= wr_over_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
      rw1_q <= rw1_d;
      rw2_q <= rw2_d;
      rw3_q <= rw3_d;
      wel_q <= wel_d;
    end
  end

  // pins and configuration straight from flops
  assign link.miso = miso_q;
  assign link.miso_oe = oe_q;
  assign block_guard = rw1_q[6:2];
  assign status_guard_zero = rw1_q[BIT_GUARD_ZERO];
  assign status_guard_one = rw2_q[BIT_GUARD_ONE];
  assign protect_invert = rw2_q[BIT_INVERT];
  assign secure_page_lock = rw2_q[5:3];
  assign quad_io_enable = rw2_q[BIT_QUAD];
  assign output_strength_field = rw3_q[6:5];
  assign write_latch_flag = wel_q;
endmodule // sfsr_device

// ==== hw/sfsr_host.sv ====
// host-side serial controller with a classic wishbone register port
`timescale 1ns/1ns
module sfsr_host
  import sfsr_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  // interrupt
  output logic irq,
  // serial link
  sfsr_spi_if.host link
);
  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_TAIL, HS_GAP} sfsr_host_state_t;

  logic [1:0] miso_s_q;
  logic [1:0] miso_s_d;

  // miso comes from outside this clock, two flops before use
  always_comb begin
    miso_s_d = {miso_s_q[0], link.miso_line};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      miso_s_q <= 2'h3;
    end else begin
      miso_s_q <= miso_s_d;
    end
  end

  sfsr_host_state_t state_q;
  sfsr_host_state_t state_d;
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [7:0] left_q;
  logic [7:0] left_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic [7:0] rx_byte_q;
  logic [7:0] rx_byte_d;
  logic [23:0] cmd_q;
  logic [23:0] cmd_d;
  logic sck_q;
  logic sck_d;
  logic cs_n_q;
  logic cs_n_d;
  logic mosi_q;
  logic mosi_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic done_q;
  logic done_d;
  logic irq_en_q;
  logic irq_en_d;
  logic irq_q;
  logic irq_d;
  logic half_end;
  logic bus_req;
  logic bus_wr;

  assign half_end = (div_q == SCK_HALF_CYC - 8'h01);
  assign bus_req = wb_cyc & wb_stb & ~ack_q;
  // writes land at the edge where the master samples ack, not at the first request edge
  assign bus_wr = wb_cyc & wb_stb & wb_we & ack_q;

  // register port, link sequencer and interrupt in one pass
  always_comb begin
    state_d = state_q;
    div_d = half_end ? 8'h00 : div_q + 8'h01;
    bit_d = bit_q;
    left_d = left_q;
    tx_d = tx_q;
    rx_d = rx_q;
    rx_byte_d = rx_byte_q;
    cmd_d = cmd_q;
    sck_d = sck_q;
    cs_n_d = cs_n_q;
    mosi_d = mosi_q;
    ack_d = bus_req;
    dat_d = 32'h0000_0000;
    done_d = done_q;
    irq_en_d = irq_en_q;
    case (state_q)
      HS_IDLE: begin
        div_d = 8'h00;
        // a command written while idle starts a frame; otherwise it is dropped
        if (bus_wr && wb_adr == ADR_CMD) begin
          cmd_d = wb_dat_i[23:0];
          tx_d = {wb_dat_i[6:0], 1'b0};
          mosi_d = wb_dat_i[7];
          left_d = wb_dat_i[15:8];
          bit_d = 3'h0;
          cs_n_d = 1'b0;
          state_d = HS_SHIFT;
        end
      end
      HS_SHIFT: begin
        if (half_end && !sck_q) begin
          sck_d = 1'b1;
          rx_d = {rx_q[6:0], miso_s_q[1]};
        end else if (half_end) begin
          sck_d = 1'b0;
          bit_d = bit_q + 3'h1;
          if (bit_q == BIT_MSB) begin
            rx_byte_d = rx_q;
            if (left_q == 8'h00) begin
              state_d = HS_TAIL;
            end else begin
              left_d = left_q - 8'h01;
              tx_d = {cmd_q[22:16], 1'b0};
              mosi_d = cmd_q[23];
            end
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
            mosi_d = tx_q[7];
          end
        end
      end
      HS_TAIL: begin
        // hold select one half period past the last falling edge
        if (half_end) begin
          cs_n_d = 1'b1;
          state_d = HS_GAP;
        end
      end
      HS_GAP: begin
        // keeps a deselect time before the next frame can start
        if (half_end) begin
          state_d = HS_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = HS_IDLE;
      end
    endcase
    if (bus_wr && wb_adr == ADR_IRQ_CLR && wb_dat_i[0]) begin
      done_d = 1'b0;
    end
    // a completion in the clearing cycle still sets the flag
    if (state_q == HS_GAP && half_end) begin
      done_d = 1'b1;
    end
    if (bus_wr && wb_adr == ADR_IRQ_EN) begin
      irq_en_d = wb_dat_i[0];
    end
    if (bus_req && !wb_we) begin
      case (wb_adr)
        ADR_CMD: dat_d = {8'h00, cmd_q};
        ADR_STATUS: dat_d = {16'h0000, rx_byte_q, 7'h00, state_q != HS_IDLE};
        ADR_IRQ_STAT: dat_d = {31'h0, done_q};
        ADR_IRQ_EN: dat_d = {31'h0, irq_en_q};
        default: dat_d = 32'h0000_0000;
      endcase
    end
    irq_d = done_d & irq_en_d;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= HS_IDLE;
      div_q <= 8'h00;
      bit_q <= 3'h0;
      left_q <= 8'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      rx_byte_q <= 8'h00;
      cmd_q <= 24'h00_0000;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      done_q <= 1'b0;
      irq_en_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      bit_q <= bit_d;
      left_q <= left_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      rx_byte_q <= rx_byte_d;
      cmd_q <= cmd_d;
      sck_q <= sck_d;
      cs_n_q <= cs_n_d;
      mosi_q <= mosi_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      done_q <= done_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
    end
  end

  // outputs straight from flops
  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;
  assign wb_dat_o = dat_q;
  assign wb_ack = ack_q;
  assign irq = irq_q;
endmodule // sfsr_host

// ==== bench/sfsr_asserts.sv ====
// concurrent checks on the serial link between the host and the device
`timescale 1ns/1ns
module sfsr_asserts (
  // system
  input wire logic clock,
  input wire logic srst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // a half period of the link clock is eight system clocks
  sequence s_high_half;
    sck [*8] ##1 !sck;
  endsequence
  sequence s_low_half;
    !sck [*8] ##1 sck;
  endsequence
  // long enough idle that the device's synchronisers have seen the release
  sequence s_idle_frame;
    cs_n [*6];
  endsequence

  AST_SCK_HIGH_HALF: assert property ($rose(sck) |-> s_high_half)
    else $error("link clock high phase is not eight cycles");
  AST_SCK_LOW_HALF: assert property ($fell(sck) |-> (!sck) [*8])
    else $error("link clock low phase is shorter than eight cycles");
  AST_FRAME_LEAD: assert property ($fell(cs_n) |-> s_low_half)
    else $error("first link clock rise not eight cycles after select");
  AST_FRAME_GAP: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select released for less than eight cycles");
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("link clock high outside a frame");
  AST_MOSI_STABLE: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("host data changed while link clock high");
  AST_MISO_STABLE: assert property (miso_oe && sck && $past(sck) |-> $stable(miso))
    else $error("device data changed while link clock high");
  AST_MISO_LOW_PHASE: assert property ($changed(miso) && $past(miso_oe) |-> !sck)
    else $error("device data changed outside the low phase");
  AST_OE_START: assert property ($rose(miso_oe) |-> !cs_n && !sck)
    else $error("device started driving outside a low phase of a frame");
  AST_OE_RELEASE: assert property ($rose(cs_n) |-> ##[0:5] !miso_oe)
    else $error("device still driving five cycles after release");
  AST_OE_IDLE: assert property (s_idle_frame |-> !miso_oe)
    else $error("device driving between frames");

  // data really came back from the device
  COV_DATA: cover property ($fell(miso_line) && !cs_n);
endmodule // sfsr_asserts

// ==== bench/tb_spi_flash_status_readout.sv ====
// self-checking bench: host controller and status device joined over the link
`timescale 1ns/1ns
module tb_spi_flash_status_readout;
  import sfsr_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack, irq;
  logic busy_in = 1'b0, erase_paused_in = 1'b0, program_paused_in = 1'b0;
  logic [4:0] block_guard;
  logic [2:0] secure_page_lock;
  logic [1:0] output_strength_field;
  logic status_guard_zero, status_guard_one, protect_invert, quad_io_enable, write_latch_flag;
  logic [31:0] wire_sr = 32'h0;
  int n_mismatch = 0, comparisons = 0;

  sfsr_spi_if link ();
  sfsr_host sfsr_host_i (.clock(clock), .srst(srst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack(wb_ack), .irq(irq), .link(link));
  sfsr_device sfsr_device_i (.clock(clock), .srst(srst), .link(link), .busy_in(busy_in),
    .erase_paused_in(erase_paused_in), .program_paused_in(program_paused_in),
    .block_guard(block_guard), .status_guard_zero(status_guard_zero),
    .status_guard_one(status_guard_one), .protect_invert(protect_invert),
    .secure_page_lock(secure_page_lock), .quad_io_enable(quad_io_enable),
    .output_strength_field(output_strength_field), .write_latch_flag(write_latch_flag));
  sfsr_asserts sfsr_asserts_i (.clock(clock), .srst(srst), .sck(link.sck), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .miso_line(link.miso_line));

  // 100 MHz system clock
  always #5 clock = ~clock;

  // what the host sees on the wire at each rising link clock within a frame
  always @(posedge link.sck) begin
    if (!link.cs_n) begin
      wire_sr = {wire_sr[30:0], link.miso_line};
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    // the slave answers one cycle after it first sees the request
    chk("wb ack latency", 32'h2, n);
  endtask

  // clear done, run one frame, poll done; returns the last whole received byte
  task automatic cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] wd,
                     output logic [7:0] rx);
    logic [31:0] q;
    int n;
    n = 0;
    wb(ADR_IRQ_CLR, 1'b1, 32'h1, q);
    wb(ADR_CMD, 1'b1, {8'h00, wd, cnt, op}, q);
    do begin
      wb(ADR_IRQ_STAT, 1'b0, 32'h0, q);
      n++;
    end while (q[0] !== 1'b1 && n < 500);
    chk("frame done", 32'h1, {31'h0, q[0]});
    wb(ADR_STATUS, 1'b0, 32'h0, q);
    rx = q[15:8];
  endtask

  // one-byte read: judged at the register port and on the wire (idle pulls high)
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    logic [7:0] rx;
    cmd(op, 8'h01, 8'h00, rx);
    chk("status byte", {24'h0, exp}, {24'h0, rx});
    chk("wire bits", {16'h0, 8'hff, exp}, {16'h0, wire_sr[15:0]});
  endtask

  // enabled write of one status byte; the latch must be gone afterwards
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    logic [7:0] rx;
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, rx);
    chk("latch set", 32'h1, {31'h0, write_latch_flag});
    cmd(op, 8'h01, d, rx);
    chk("latch clear", 32'h0, {31'h0, write_latch_flag});
  endtask

  task automatic t_defaults;
    logic [31:0] q;
    rd(8'h05, 8'h00);
    rd(8'h35, 8'h00);
    rd(8'h15, 8'h60);
    chk("strength", 32'h3, {30'h0, output_strength_field});
    chk("latch", 32'h0, {31'h0, write_latch_flag});
    wb(8'h20, 1'b1, 32'hffffffff, q);
    wb(8'h20, 1'b0, 32'h0, q);
    chk("unmapped", 32'h0, q);
    wb(ADR_IRQ_EN, 1'b0, 32'h0, q);
    chk("irq enable", 32'h0, q);
    $display("test defaults finished");
  endtask

  task automatic t_write;
    logic [7:0] rx;
    logic [1:0] v;
    // a write without the latch must be ignored
    cmd(8'h01, 8'h01, 8'hff, rx);
    rd(8'h05, 8'h00);
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, rx);
    // an unknown opcode leaves the latch alone
    cmd(8'ha5, 8'h00, 8'h00, rx);
    rd(8'h05, 8'h02);
    cmd(OP_WRITE_DISABLE, 8'h00, 8'h00, rx);
    chk("latch off", 32'h0, {31'h0, write_latch_flag});
    wr(8'h01, 8'hff);
    busy_in <= 1'b1;
    rd(8'h05, 8'hfd);
    chk("guards", 32'h3f, {26'h0, status_guard_zero, block_guard});
    busy_in <= 1'b0;
    // a write frame with a second data byte must be dropped
    cmd(OP_WRITE_ENABLE, 8'h00, 8'h00, rx);
    cmd(8'h01, 8'h02, 8'h00, rx);
    rd(8'h05, 8'hfc);
    chk("latch long write", 32'h0, {31'h0, write_latch_flag});
    wr(8'h31, 8'hff);
    erase_paused_in <= 1'b1;
    rd(8'h35, 8'hfb);
    chk("byte two outs", 32'h3f, {26'h0, protect_invert, secure_page_lock, quad_io_enable,
        status_guard_one});
    erase_paused_in <= 1'b0;
    program_paused_in <= 1'b1;
    rd(8'h35, 8'h7f);
    program_paused_in <= 1'b0;
    wr(8'h31, 8'h84);
    rd(8'h35, 8'h00);
    chk("quad off", 32'h0, {31'h0, quad_io_enable});
    // every strength code, with reserved bits written high
    for (int s = 0; s < 4; s++) begin
      v = 2'(s);
      wr(8'h11, {1'b1, v, 5'h1f});
      rd(8'h15, {1'b0, v, 5'h00});
      chk("strength", {30'h0, v}, {30'h0, output_strength_field});
    end
    $display("test write finished");
  endtask

  // busy drops in the middle of the first status byte of one long read, before its repeat
  task automatic t_repeat;
    logic [7:0] rx;
    wb_dat_i <= 32'h0;
    busy_in <= 1'b1;
    fork
      cmd(8'h05, 8'h02, 8'h00, rx);
      begin
        repeat (200) @(posedge clock);
        busy_in <= 1'b0;
      end
    join
    chk("last repeat", 32'hfc, {24'h0, rx});
    chk("wire repeats", 32'hfffdfc, {8'h0, wire_sr[23:0]});
    $display("test repeat finished");
  endtask

  task automatic t_irq;
    logic [31:0] q;
    logic [7:0] rx;
    wb(ADR_IRQ_EN, 1'b1, 32'h1, q);
    cmd(8'h05, 8'h01, 8'h00, rx);
    chk("irq raised", 32'h1, {31'h0, irq});
    wb(ADR_IRQ_CLR, 1'b1, 32'h1, q);
    wb(ADR_IRQ_STAT, 1'b0, 32'h0, q);
    chk("done cleared", 32'h0, q);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wb(ADR_IRQ_EN, 1'b1, 32'h0, q);
    cmd(8'h35, 8'h01, 8'h00, rx);
    wb(ADR_IRQ_STAT, 1'b0, 32'h0, q);
    chk("done masked", 32'h1, q);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test irq finished");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the tests need just over a tenth of this span
  initial begin
    #900000;
    n_mismatch++;
    give_verdict();
  end

  // reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    t_defaults();
    t_write();
    t_repeat();
    t_irq();
    give_verdict();
  end
endmodule // tb_spi_flash_status_readout
